/* File: sffcs_pkg.sv */
package sffcs_pkg;

	// ----------------------------------------
	// Register indices on the plain port
	// ----------------------------------------
	localparam logic [2:0] A_FMT = 3'h0;
	localparam logic [2:0] A_CTL = 3'h1;
	localparam logic [2:0] A_BRR = 3'h2;
	localparam logic [2:0] A_TDR = 3'h3;
	localparam logic [2:0] A_RDR = 3'h4;
	localparam logic [2:0] A_STS = 3'h5;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int F_SYNC = 7;
	localparam int F_CHR  = 6;
	localparam int F_PE   = 5;
	localparam int F_ODD  = 4;
	localparam int F_STOP = 3;
	localparam int F_MP   = 2;
	localparam int C_LINE = 7;
	localparam int C_TE   = 5;
	localparam int C_RE   = 4;
	localparam int C_CKHI = 1;
	localparam int C_CKLO = 0;
	localparam int S_TDRE = 7;
	localparam int S_RDRF = 6;
	localparam int S_OVR  = 5;
	localparam int S_FER  = 4;
	localparam int S_PER  = 3;
	localparam int S_TEND = 2;
	localparam int S_MPB  = 1;
	localparam int S_MPBT = 0;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] FMT_RST     = 8'h00;
	localparam logic [7:0] CTL_RST     = 8'h00;
	localparam logic [7:0] BRR_RST     = 8'hff;
	localparam logic [7:0] STS_RST     = 8'h84;
	localparam logic [3:0] OVS_LAST    = 4'hf;
	localparam logic [3:0] OVS_MID     = 4'h7;
	localparam logic [3:0] DLEN8       = 4'h8;
	localparam logic [3:0] DLEN7       = 4'h7;
	localparam logic [3:0] STOP0       = 4'h0;
	localparam logic [3:0] STOP1       = 4'h1;
	localparam logic [3:0] STOP2       = 4'h2;
	localparam logic [3:0] SYNC_LEN    = 4'h8;
	localparam logic [3:0] SYNC_TX_LEN = 4'h9;
	localparam int         RSR_W       = 10;
	localparam int         TSR_W       = 12;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} sffcs_tx_e;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} sffcs_rx_e;

	function automatic logic sffcs_par(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : sffcs_par

	function automatic logic [7:0] sffcs_mask(input logic [7:0] d, input logic [3:0] n);
		return (n == DLEN7) ? {1'b0, d[6:0]} : d;
	endfunction : sffcs_mask

endpackage : sffcs_pkg

/* File: sffcs_top.sv */
// Operation
// - Two modes: per-character framed asynchronous, or clocked synchronous.
// - Format bit 7 low selects asynchronous, high selects synchronous.
// - Async character length bit: 0 gives eight data bits, 1 gives seven.
// - Async stop length bit: 0 gives one stop bit, 1 gives two.
// - Without multiprocessor format, parity enable adds one parity bit after data.
// - Multiprocessor format adds one marker bit, no parity; twelve formats total.
// - Frame is low start, data LSB first, parity or marker, high stops.
// - Idle async line rests high; a character starts at first high-to-low edge.
// - Receiver syncs on start edge, samples mid-bit at 8th of 16 ticks.
// - Async receiver flags framing, parity and overrun; break is recognisable.
// - Transmit and receive run independently for full duplex.
// - Transmit and receive are double buffered for gapless streams.
// - Async internal clock from baud generator; pin unused when low select clear.
// - Async internal with low select set drives bit-rate clock on the pin.
// - Sync character is eight data bits, no parity, marker or stop.
// - Sync receiver detects only overrun.
// - Sync internal: baud generator clocks unit and clock is driven out.
// - Sync external: partner drives clock in; unit shifts on it.
// - Clock source and pin role decode from mode and both clock selects.
// - Present parity bit is checked against even or odd setting.
// - With two stop bits only the first is checked for framing.
// - After stop bits the transmitter holds the line high until next start.
`timescale 1ns/1ps
module sffcs_top import sffcs_pkg::*; (
	input  logic       ref_clk,
	input  logic       reset,
	input  logic [2:0] reg_addr,
	input  logic [7:0] reg_wdata,
	input  logic       reg_wr,
	input  logic       reg_rd,
	output logic [7:0] reg_rdata,
	output logic       txd_o,
	output logic       txd_oe,
	input  logic       rxd_i,
	input  logic       sck_i,
	output logic       sck_o,
	output logic       sck_oe
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]       fmt_q, fmt_d, ctl_q, ctl_d, brr_q, brr_d;
	logic [7:0]       tdr_q, tdr_d, rdr_q, rdr_d, sts_q, sts_d;
	logic [7:0]       rdata_q, rdata_d, brg_q, brg_d;
	logic             sck_s_q, sck_s_d, sck_p_q, sck_p_d;
	logic             sclk_q, sclk_d, scko_q, scko_d, sckoe_q, sckoe_d;
	logic             txd_q, txd_d, txoe_q, txoe_d;
	sffcs_tx_e        tx_st_q, tx_st_d;
	logic [TSR_W-1:0] tsr_q, tsr_d;
	logic [3:0]       txl_q, txl_d, txp_q, txp_d;
	sffcs_rx_e        rx_st_q, rx_st_d;
	logic [RSR_W-1:0] rsr_q, rsr_d;
	logic [3:0]       rxc_q, rxc_d, rxn_q, rxn_d;
	logic             rxl_q, rxl_d, rxp_q, rxp_d;

	// ----------------------------------------
	// Mode and format decode
	// ----------------------------------------
	logic       async, ext, te, re, mp, pe_eff, xb, cfg_ok;
	logic [3:0] dlen, nst, flen, rnum;
	logic       brg_tick, tick16, s_run, s_rise, s_fall, tx_end;

	assign async  = ~fmt_q[F_SYNC];
	assign ext    = ctl_q[C_CKHI];
	assign te     = ctl_q[C_TE];
	assign re     = ctl_q[C_RE];
	assign mp     = fmt_q[F_MP];
	assign pe_eff = fmt_q[F_PE] & ~mp;
	assign xb     = async & (mp | fmt_q[F_PE]);
	assign dlen   = (async & fmt_q[F_CHR]) ? DLEN7 : DLEN8;
	assign nst    = ~async ? STOP0 : (fmt_q[F_STOP] ? STOP2 : STOP1);
	assign flen   = STOP1 + dlen + {3'h0, xb} + nst;
	// Receiver only collects the first stop bit
	assign rnum   = async ? (dlen + {3'h0, xb} + STOP1) : SYNC_LEN;
	assign cfg_ok = ~te & ~re;

	// ----------------------------------------
	// Clock source and pin
	// ----------------------------------------
	assign brg_tick = (brg_q == brr_q);
	// External 16x clock counts only its rising edges
	assign tick16   = ext ? (sck_s_q & ~sck_p_q) : brg_tick;
	assign s_run    = (tx_st_q == TX_BUSY) | (re & ~sts_q[S_OVR]);
	assign s_rise   = ext ? (sck_s_q & ~sck_p_q) : (brg_tick & s_run & ~sclk_q);
	assign s_fall   = ext ? (~sck_s_q & sck_p_q) : (brg_tick & s_run & sclk_q);

	always_comb begin
		brg_d   = brg_tick ? 8'h00 : brg_q + 8'h01;
		sck_s_d = sck_i;
		sck_p_d = sck_s_q;
		sclk_d  = sclk_q;
		// The falling edge that only ends a frame is held back, so no ninth pulse appears
		if (!s_run || (tx_end && !(re && !sts_q[S_OVR])))
			sclk_d = 1'b1;
		else if (brg_tick)
			sclk_d = ~sclk_q;
		if (async) begin
			sckoe_d = ~ext & ctl_q[C_CKLO];
			// Rises at the centre of each transmit bit
			scko_d  = txp_q[3];
		end else begin
			sckoe_d = ~ext;
			// Pin follows the shift clock so data moves only on falling edges
			scko_d  = sclk_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			brg_q   <= 8'h00;
			sck_s_q <= 1'b1;
			sck_p_q <= 1'b1;
			sclk_q  <= 1'b1;
			scko_q  <= 1'b1;
			sckoe_q <= 1'b0;
		end else begin
			brg_q   <= brg_d;
			sck_s_q <= sck_s_d;
			sck_p_q <= sck_p_d;
			sclk_q  <= sclk_d;
			scko_q  <= scko_d;
			sckoe_q <= sckoe_d;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	logic [TSR_W-1:0] frm;
	logic [7:0]       tdm;
	logic             tx_step, tx_load;

	always_comb begin
		tdm = sffcs_mask(tdr_q, dlen);
		frm = '1;
		if (async) begin
			frm[0] = 1'b0;
			for (int i = 0; i < 8; i++) begin
				if (i < int'(dlen))
					frm[i+1] = tdm[i];
			end
			if (xb)
				frm[dlen+4'h1] = mp ? sts_q[S_MPBT] : sffcs_par(tdm, fmt_q[F_ODD]);
		end else begin
			// Leading filler is consumed by the first falling clock edge
			frm = {3'h7, tdr_q, 1'b1};
		end
	end

	assign tx_step = async ? (tick16 & (txp_q == OVS_LAST)) : s_fall;

	always_comb begin
		tx_st_d = tx_st_q;
		tsr_d   = tsr_q;
		txl_d   = txl_q;
		txp_d   = tick16 ? txp_q + 4'h1 : txp_q;
		tx_load = 1'b0;
		tx_end  = 1'b0;
		unique case (tx_st_q)
			TX_IDLE: begin
				// Async start waits for a bit boundary so the start bit is never short
				if (te && !sts_q[S_TDRE] && (tx_step || !async)) begin
					tsr_d   = frm;
					txl_d   = async ? flen : SYNC_TX_LEN;
					tx_st_d = TX_BUSY;
					tx_load = 1'b1;
				end
			end
			TX_BUSY: begin
				if (tx_step) begin
					tsr_d = {1'b1, tsr_q[TSR_W-1:1]};
					txl_d = txl_q - 4'h1;
					if (txl_q == 4'h1) begin
						if (te && !sts_q[S_TDRE]) begin
							// Back to back frames skip the sync filler bit
							tsr_d   = async ? frm : {1'b1, frm[TSR_W-1:1]};
							txl_d   = async ? flen : SYNC_LEN;
							tx_load = 1'b1;
						end else begin
							tx_st_d = TX_IDLE;
							tx_end  = 1'b1;
						end
					end
				end
			end
		endcase
		if (!te) begin
			tx_st_d = TX_IDLE;
			tsr_d   = '1;
			tx_load = 1'b0;
		end
		txd_d  = (tx_st_d == TX_BUSY) ? tsr_d[0] : 1'b1;
		txoe_d = te;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_st_q <= TX_IDLE;
			tsr_q   <= '1;
			txl_q   <= 4'h0;
			txp_q   <= 4'h0;
			txd_q   <= 1'b1;
			txoe_q  <= 1'b0;
		end else begin
			tx_st_q <= tx_st_d;
			tsr_q   <= tsr_d;
			txl_q   <= txl_d;
			txp_q   <= txp_d;
			txd_q   <= txd_d;
			txoe_q  <= txoe_d;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	logic             rx_en, samp, rx_fin, rx_ok, rx_ovr, rx_fer, rx_per;
	logic [RSR_W-1:0] val;
	logic [7:0]       rx_dat;

	// Any error flag blocks reception until software clears it
	assign rx_en = re & ~(sts_q[S_OVR] | sts_q[S_FER] | sts_q[S_PER]);
	assign samp  = async ? (tick16 & (rxc_q == OVS_MID)) : s_rise;

	always_comb begin
		rx_st_d = rx_st_q;
		rsr_d   = rsr_q;
		rxc_d   = rxc_q;
		rxn_d   = rxn_q;
		rxl_d   = rxd_i;
		rxp_d   = rxl_q;
		rx_fin  = 1'b0;
		unique case (rx_st_q)
			RX_IDLE: begin
				if (rx_en && async && rxp_q && !rxl_q) begin
					rx_st_d = RX_START;
					rxc_d   = 4'h0;
				end else if (rx_en && !async) begin
					rx_st_d = RX_BITS;
					rxn_d   = SYNC_LEN;
				end
			end
			RX_START: begin
				if (tick16) begin
					rxc_d = rxc_q + 4'h1;
					if (rxc_q == OVS_MID) begin
						if (rxl_q) begin
							rx_st_d = RX_IDLE;
						end else begin
							rx_st_d = RX_BITS;
							rxn_d   = rnum;
						end
					end
				end
			end
			RX_BITS: begin
				if (tick16)
					rxc_d = rxc_q + 4'h1;
				if (samp) begin
					rsr_d = {rxl_q, rsr_q[RSR_W-1:1]};
					rxn_d = rxn_q - 4'h1;
					if (rxn_q == 4'h1) begin
						rx_fin  = 1'b1;
						rx_st_d = async ? RX_IDLE : RX_BITS;
						rxn_d   = SYNC_LEN;
					end
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
		if (!rx_en)
			rx_st_d = RX_IDLE;
	end

	always_comb begin
		val    = rsr_d >> (RSR_W - int'(rnum));
		rx_dat = sffcs_mask(val[7:0], dlen);
		rx_ovr = rx_fin & sts_q[S_RDRF];
		// Only the first stop bit lands in the top of the shifter
		rx_fer = rx_fin & async & ~rsr_d[RSR_W-1];
		rx_per = rx_fin & async & pe_eff &
			(val[dlen] != sffcs_par(rx_dat, fmt_q[F_ODD]));
		rx_ok  = rx_fin & ~rx_ovr & ~rx_fer & ~rx_per;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_st_q <= RX_IDLE;
			rsr_q   <= '0;
			rxc_q   <= 4'h0;
			rxn_q   <= 4'h0;
			rxl_q   <= 1'b1;
			rxp_q   <= 1'b1;
		end else begin
			rx_st_q <= rx_st_d;
			rsr_q   <= rsr_d;
			rxc_q   <= rxc_d;
			rxn_q   <= rxn_d;
			rxl_q   <= rxl_d;
			rxp_q   <= rxp_d;
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb begin
		fmt_d   = fmt_q;
		ctl_d   = ctl_q;
		brr_d   = brr_q;
		tdr_d   = tdr_q;
		rdr_d   = rdr_q;
		sts_d   = sts_q;
		rdata_d = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				A_FMT: if (cfg_ok) fmt_d = reg_wdata;
				A_CTL: begin
					ctl_d[C_TE] = reg_wdata[C_TE];
					ctl_d[C_RE] = reg_wdata[C_RE];
					if (cfg_ok) begin
						ctl_d[C_CKHI] = reg_wdata[C_CKHI];
						ctl_d[C_CKLO] = reg_wdata[C_CKLO];
					end
				end
				A_BRR: if (cfg_ok) brr_d = reg_wdata;
				A_TDR: begin
					tdr_d         = reg_wdata;
					sts_d[S_TDRE] = 1'b0;
					sts_d[S_TEND] = 1'b0;
				end
				A_STS: begin
					// Receive and error flags clear by writing zero over them; TDRE and TEND ignore this write
					sts_d[S_RDRF] = sts_q[S_RDRF] & reg_wdata[S_RDRF];
					sts_d[S_OVR]  = sts_q[S_OVR] & reg_wdata[S_OVR];
					sts_d[S_FER]  = sts_q[S_FER] & reg_wdata[S_FER];
					sts_d[S_PER]  = sts_q[S_PER] & reg_wdata[S_PER];
					sts_d[S_MPBT] = reg_wdata[S_MPBT];
				end
				default: ;
			endcase
		end
		if (te && !ctl_d[C_TE])
			sts_d[S_TDRE] = 1'b1;
		// Hardware sets after software clears so no event is lost
		if (tx_load) begin
			sts_d[S_TDRE] = 1'b1;
			sts_d[S_TEND] = 1'b0;
		end
		if (tx_end)
			sts_d[S_TEND] = 1'b1;
		if (rx_ok) begin
			rdr_d         = rx_dat;
			sts_d[S_RDRF] = 1'b1;
			if (mp)
				sts_d[S_MPB] = val[dlen];
		end
		if (rx_ovr)
			sts_d[S_OVR] = 1'b1;
		if (rx_fer)
			sts_d[S_FER] = 1'b1;
		if (rx_per)
			sts_d[S_PER] = 1'b1;
		if (reg_rd) begin
			unique case (reg_addr)
				A_FMT: rdata_d = fmt_q;
				// Line level lets software tell a break from a bad stop bit
				A_CTL: rdata_d = {rxl_q, ctl_q[6:0]};
				A_BRR: rdata_d = brr_q;
				A_TDR: rdata_d = tdr_q;
				A_RDR: rdata_d = rdr_q;
				A_STS: rdata_d = sts_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fmt_q   <= FMT_RST;
			ctl_q   <= CTL_RST;
			brr_q   <= BRR_RST;
			tdr_q   <= 8'h00;
			rdr_q   <= 8'h00;
			sts_q   <= STS_RST;
			rdata_q <= 8'h00;
		end else begin
			fmt_q   <= fmt_d;
			ctl_q   <= ctl_d;
			brr_q   <= brr_d;
			tdr_q   <= tdr_d;
			rdr_q   <= rdr_d;
			sts_q   <= sts_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign txd_o     = txd_q;
	assign txd_oe    = txoe_q;
	assign sck_o     = scko_q;
	assign sck_oe    = sckoe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_mid_low;
		rx_st_q == RX_START && tick16 && rxc_q == OVS_MID && !rxl_q;
	endsequence
	sequence s_mid_high;
		rx_st_q == RX_START && tick16 && rxc_q == OVS_MID && rxl_q;
	endsequence

	a_pin_unused: assert property ((async && !ext && !ctl_q[C_CKLO]) |=> !sck_oe)
		else $error("clock pin driven while unused");
	a_async_ckout: assert property ((async && !ext && ctl_q[C_CKLO])
		|=> sck_oe && sck_o == $past(txp_q[3]))
		else $error("async bit clock output wrong");
	a_sync_ckout: assert property ((!async && !ext) |=> sck_oe)
		else $error("sync clock not driven");
	a_ext_ckin: assert property (ext |=> !sck_oe)
		else $error("external clock pin driven");
	a_start_low: assert property ((tx_load && async && tx_st_q == TX_IDLE) |=> !txd_o)
		else $error("start bit not low");
	a_mark_idle: assert property ((tx_st_q == TX_IDLE && !tx_load) |=> txd_o)
		else $error("idle line not high");
	a_cfg_lock: assert property ((!cfg_ok && reg_wr && reg_addr == A_FMT) |=> $stable(fmt_q))
		else $error("format changed while enabled");
	a_noise_drop: assert property (s_mid_high |=> rx_st_q == RX_IDLE)
		else $error("noise start not dropped");
	a_start_ok: assert property (s_mid_low ##1 (rx_st_q == RX_BITS)[*2]
		|-> rxn_q == rnum)
		else $error("valid start not taken");
	a_ovr_keep: assert property (rx_ovr |=> $stable(rdr_q) && sts_q[S_OVR])
		else $error("overrun data loaded");
	a_sync_nofer: assert property ((!async && rx_fin) |=> !$rose(sts_q[S_FER]))
		else $error("framing error in sync mode");
	a_rdrf_set: assert property (rx_ok |=> sts_q[S_RDRF] && rdr_q == $past(rx_dat))
		else $error("received data not posted");

endmodule : sffcs_top

/* File: sffcs_peer.sv */
`timescale 1ns/1ps
module sffcs_peer (
	input  logic ref_clk,
	input  logic txd_o,
	input  logic sck_o,
	output logic rxd_i,
	output logic sck_i
);

	// Line rests at mark until a frame is sent
	initial rxd_i = 1'b1;
	// Clock pin rests high outside transfers
	initial sck_i = 1'b1;

	// ----------------------------------------
	// Sending: bit 0 of the vector goes first
	// ----------------------------------------
	task automatic send(input logic [31:0] b, input int n, input int len);
		for (int i = 0; i < n; i++) begin
			rxd_i <= b[i];
			repeat (len) @(posedge ref_clk);
		end
	endtask : send

	// External 16x clock: toggles each cycle, so it rises every two cycles
	task automatic tick(input int n);
		for (int i = 0; i < n; i++) begin
			sck_i <= ~sck_i;
			@(posedge ref_clk);
		end
	endtask : tick

	// Clocked byte into the unit: data changes with the falling edge
	task automatic sync_send(input logic [7:0] b, input int half);
		for (int i = 0; i < 8; i++) begin
			sck_i <= 1'b0;
			rxd_i <= b[i];
			repeat (half) @(posedge ref_clk);
			sck_i <= 1'b1;
			repeat (half) @(posedge ref_clk);
		end
	endtask : sync_send

	// ----------------------------------------
	// Capture on each rising edge of the clock pin
	// ----------------------------------------
	// Async: the start bit's own mid-bit rise comes 9 cycles after its edge, so the
	// first 13 cycles are skipped and the start bit is never captured.
	task automatic grab(input logic async, input int n, output logic [31:0] b, output int got);
		int   idle;
		logic last;
		b = '0;
		got = 0;
		idle = 0;
		if (async) begin
			while (txd_o !== 1'b0 && idle < 1000) begin
				@(posedge ref_clk);
				idle++;
			end
			repeat (12) @(posedge ref_clk);
		end
		last = sck_o;
		idle = 0;
		while (got < n && idle < 100) begin
			@(posedge ref_clk);
			idle++;
			if (sck_o === 1'b1 && last === 1'b0) begin
				b[got] = txd_o;
				got++;
				idle = 0;
			end
			last = sck_o;
		end
	endtask : grab

endmodule : sffcs_peer

/* File: tb.sv */
`timescale 1ns/1ps
module tb import sffcs_pkg::*;;

	logic        ref_clk;
	logic        reset;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        txd_o;
	logic        txd_oe;
	logic        rxd_i;
	logic        sck_o;
	logic        sck_oe;
	logic        sck_i;
	int          bad_count;
	int          checked;
	int          k;
	int          got;
	logic [31:0] exp;
	logic [31:0] bits;
	logic [7:0]  rx_d[6]   = '{8'h5c, 8'ha3, 8'h0f, 8'hc1, 8'h7e, 8'h96};
	logic [7:0]  rx_sts[6] = '{8'h40, 8'h08, 8'h10, 8'h40, 8'h40, 8'h60};
	int          rx_flip[6] = '{0, 9, 10, 11, 0, 0};

	sffcs_top i_dut (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.reg_addr (reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr   (reg_wr),
		.reg_rd   (reg_rd),
		.reg_rdata(reg_rdata),
		.txd_o    (txd_o),
		.txd_oe   (txd_oe),
		.rxd_i    (rxd_i),
		.sck_i    (sck_i),
		.sck_o    (sck_o),
		.sck_oe   (sck_oe)
	);

	sffcs_peer i_peer (
		.ref_clk(ref_clk),
		.txd_o  (txd_o),
		.sck_o  (sck_o),
		.rxd_i  (rxd_i),
		.sck_i  (sck_i)
	);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		checked++;
		if (v !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, v);
			bad_count++;
		end
	endtask : chk

	// A spare cycle after each strobe keeps one assignment per signal per time step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		@(posedge ref_clk);
		v = reg_rdata;
	endtask : rd

	task automatic rchk(input string s, input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(s, e, v & m);
	endtask : rchk

	task automatic wait_tdre();
		logic [7:0] v;
		for (int i = 0; i < 200; i++) begin
			rd(A_STS, v);
			if (v[S_TDRE] === 1'b1)
				break;
		end
	endtask : wait_tdre

	task automatic put(input logic b);
		exp[k] = b;
		k++;
	endtask : put

	task automatic add_frame(input logic [7:0] f, input logic [7:0] d, input logic address_marker_bit,
		input logic skip_start);
		int n;
		n = f[F_CHR] ? 7 : 8;
		if (!skip_start)
			put(1'b0);
		for (int i = 0; i < n; i++)
			put(d[i]);
		if (f[F_MP])
			put(address_marker_bit);
		else if (f[F_PE])
			put((^(d & (f[F_CHR] ? 8'h7f : 8'hff))) ^ f[F_ODD]);
		for (int i = 0; i <= f[F_STOP]; i++)
			put(1'b1);
	endtask : add_frame

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [7:0] f;
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk("txd idle", 1, txd_o);
		chk("txd oe", 0, txd_oe);
		rchk("fmt", A_FMT, 8'hff, FMT_RST);
		rchk("ctl", A_CTL, 8'hff, CTL_RST | 8'h80);
		rchk("brr", A_BRR, 8'hff, BRR_RST);
		rchk("sts", A_STS, 8'hff, STS_RST);
		rchk("unmapped", 3'h6, 8'hff, 8'h00);
		$display("test reset finished");
		for (int i = 0; i < 8; i++) begin
			wr(A_FMT, {i[2], 7'h00});
			wr(A_CTL, {6'h00, i[1:0]});
			repeat (2) @(posedge ref_clk);
			chk("sck oe", !i[1] && (i[2] || i[0]), sck_oe);
		end
		$display("test clock select finished");
		wr(A_BRR, 8'h00);
		// All sixteen codings: the four with marker and parity both set must ignore parity
		for (int i = 0; i < 16; i++) begin
			f = {1'b0, i[3], i[2], i[3] ^ i[0], i[0], i[1], 2'b00};
			wr(A_CTL, 8'h00);
			wr(A_FMT, f);
			wr(A_STS, 8'h01);
			wr(A_CTL, 8'h21);
			@(posedge ref_clk);
			chk("txd oe", 1, txd_oe);
			k = 0;
			exp = '0;
			add_frame(f, 8'h9a, 1'b1, 1'b1);
			add_frame(f, 8'h35, 1'b1, 1'b0);
			put(1'b1);
			fork
				i_peer.grab(1'b1, k, bits, got);
				begin
					wr(A_TDR, 8'h9a);
					wait_tdre();
					wr(A_TDR, 8'h35);
				end
			join
			chk("tx bits", exp, bits);
			chk("tx count", k, got);
		end
		$display("test async transmit finished");
		wr(A_CTL, 8'h00);
		wr(A_FMT, 8'h28);
		for (int c = 0; c < 6; c++) begin
			wr(A_CTL, 8'h00);
			wr(A_STS, 8'h00);
			wr(A_CTL, 8'h10);
			k = 0;
			exp = '0;
			add_frame(8'h28, rx_d[c], 1'b0, 1'b0);
			put(1'b1);
			if (rx_flip[c] > 0)
				exp[rx_flip[c]] = ~exp[rx_flip[c]];
			if (c == 4)
				i_peer.send(32'h6, 3, 5);
			if (c == 5)
				i_peer.send(exp, k, 16);
			i_peer.send(exp, k, 16);
			rchk("rx status", A_STS, 8'h78, rx_sts[c]);
			if (rx_sts[c][S_RDRF])
				rchk("rx data", A_RDR, 8'hff, rx_d[c]);
		end
		wr(A_CTL, 8'h00);
		wr(A_STS, 8'h00);
		wr(A_CTL, 8'h12);
		k = 0;
		exp = '0;
		add_frame(8'h28, 8'h3c, 1'b0, 1'b0);
		put(1'b1);
		fork
			i_peer.tick(k * 32 + 8);
			i_peer.send(exp, k, 32);
		join
		rchk("ext rx status", A_STS, 8'h78, 8'h40);
		rchk("ext rx data", A_RDR, 8'hff, 8'h3c);
		$display("test async receive finished");
		wr(A_CTL, 8'h00);
		wr(A_FMT, 8'h80);
		wr(A_CTL, 8'h20);
		fork
			i_peer.grab(1'b0, 9, bits, got);
			wr(A_TDR, 8'h3c);
		join
		chk("sync bits", 32'h3c, bits);
		chk("sync count", 8, got);
		wr(A_FMT, 8'h00);
		rchk("fmt locked", A_FMT, 8'hff, 8'h80);
		$display("test sync transmit finished");
		wr(A_CTL, 8'h00);
		wr(A_STS, 8'h00);
		wr(A_CTL, 8'h12);
		i_peer.sync_send(8'ha5, 4);
		rchk("sync rx status", A_STS, 8'h78, 8'h40);
		rchk("sync rx data", A_RDR, 8'hff, 8'ha5);
		i_peer.sync_send(8'h5a, 4);
		rchk("sync overrun", A_STS, 8'h78, 8'h60);
		rchk("sync rx kept", A_RDR, 8'hff, 8'ha5);
		$display("test sync receive finished");
		final_report();
	end

	initial begin
		bad_count = 0;
		checked = 0;
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end

endmodule : tb
